// ---- sdr_host_model.sv ----
// Controller model that clocks results out of the converter.
`timescale 1ns/10ps
module sdr_host_model
(
  input  wire logic dataOutReadyLine,
  output logic      serialClk
);
  logic [23:0] word;
  // The clock rests low between reads and runs free of the system clock.
  initial serialClk = 1'b0;
  // Half period of 140 ns leaves the sync chain time to put the bit out.
  task automatic readWord();
    repeat (24)
    begin
      #140 serialClk = 1'b1;
      #140 serialClk = 1'b0;
      word = {word[22:0], dataOutReadyLine};
    end
    // A low last bit would pass for a ready flag; rest until the line is released.
    #200;
  endtask
  task automatic holdHigh(input int ns);
    serialClk = 1'b1;
    #(ns) serialClk = 1'b0;
  endtask
endmodule

// ---- sdr_readout.v ----
// Delta-sigma decimation filter and serial result readout.
`timescale 1ns/10ps
`include "sdr_regs.vh"

module sdr_readout
#(
  parameter RESYNC_CYCLES = `SDR_RESYNC_CYCLES,
  parameter PDOWN_CYCLES  = `SDR_PDOWN_CYCLES
)
(
  input  wire        clock,
  input  wire        reset,
  input  wire        modBit,
  input  wire        serialClk,
  output reg         dataOutReadyLine,
  output reg         modResync,
  output reg         powerDown,
  output reg         settled
);

  // ----------------------------------------------------------------
  // Serial clock and modulator bit synchronisers
  // ----------------------------------------------------------------
  reg        sclkMeta_q;
  reg        sclkSync_q;
  reg        sclkLast_q;
  reg        modMeta_q;
  reg        modSync_q;

  // Both pins pass two flops; the second stage is read, and the serial clock also has a third stage that is read for edge detection.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sclkMeta_q <= 1'b0;
      sclkSync_q <= 1'b0;
      sclkLast_q <= 1'b0;
      modMeta_q  <= 1'b0;
      modSync_q  <= 1'b0;
    end
    else
    begin
      sclkMeta_q <= serialClk;
      sclkSync_q <= sclkMeta_q;
      sclkLast_q <= sclkSync_q;
      modMeta_q  <= modBit;
      modSync_q  <= modMeta_q;
    end
  end

  // Rising edge of the synchronised serial clock, a single clock wide.
  wire sclkRise = sclkSync_q & ~sclkLast_q;

  // ----------------------------------------------------------------
  // Modulator clock enable and sinc5 filter
  // ----------------------------------------------------------------
  // Rate strobes; both stop while the block sleeps so the filter holds still.
  reg  [2:0]  divCnt_q;
  reg  [5:0]  osrCnt_q;
  reg  [2:0]  settleCnt_q;
  wire [35:0] integIn   [0:4];
  wire [35:0] integOut  [0:4];
  wire [35:0] combOut   [0:5];
  wire        modEn  = (divCnt_q == `SDR_MOD_DIV - 3'd1) & ~powerDown;
  wire        decEn  = modEn & (osrCnt_q == `SDR_OSR);
  wire [35:0] inSample = {35'd0, modSync_q};

  // Divide the system clock by six to time the modulator.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      divCnt_q <= 3'd0;
    else if (modEn || divCnt_q == `SDR_MOD_DIV - 3'd1 || modResync)
      divCnt_q <= 3'd0;
    else
      divCnt_q <= divCnt_q + 3'd1;
  end

  // Count modulator samples per result; resync restarts the frame.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      osrCnt_q <= 6'd0;
    else if (modResync)
      osrCnt_q <= 6'd0;
    else if (modEn)
      osrCnt_q <= osrCnt_q + 6'd1;
  end

  // Five integrators and five combs; modulo arithmetic makes wrap harmless.
  // Each stage keeps its own registers so every flop has a single driver.
  assign combOut[0] = integOut[4];
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : gStage
      reg [35:0] integ_q;
      reg [35:0] combDly_q;

      // The first integrator takes the modulator bit, the rest chain on.
      if (gi == 0)
      begin : gHead
        assign integIn[gi] = inSample;
      end
      else
      begin : gChain
        assign integIn[gi] = integOut[gi - 1];
      end

      // Integrators run at the modulator rate, combs at the result rate.
      always @(posedge clock or posedge reset)
      begin
        if (reset)
        begin
          integ_q   <= 36'd0;
          combDly_q <= 36'd0;
        end
        else if (modResync)
        begin
          integ_q   <= 36'd0;
          combDly_q <= 36'd0;
        end
        else
        begin
          if (modEn)
            integ_q <= integIn[gi] + integ_q;
          if (decEn)
            combDly_q <= combOut[gi];
        end
      end

      // Each comb feeds the next stage; the last one is the filter output.
      assign integOut[gi]    = integ_q;
      assign combOut[gi + 1] = combOut[gi] - combDly_q;
    end
  endgenerate

  // Full scale 64^5 is 2^30; keep 24 bits, clipping the single overflow code.
  wire [23:0] result = combOut[5][30] ? 24'hffffff : combOut[5][29:6];

  // ----------------------------------------------------------------
  // Output register and shifter
  // ----------------------------------------------------------------
  reg [23:0] shift_q;
  reg [4:0]  bitCnt_q;
  reg        loaded_q;

  // A new result loads only between reads so a word is never torn.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      shift_q          <= 24'h000000;
      bitCnt_q         <= 5'd0;
      loaded_q         <= 1'b0;
      dataOutReadyLine <= 1'b1;
    end
    else if (powerDown || modResync)
    begin
      loaded_q         <= 1'b0;
      bitCnt_q         <= 5'd0;
      dataOutReadyLine <= 1'b1;
    end
    // A serial edge outranks a new result, so an edge is never lost.
    else if (loaded_q && sclkRise)
    begin
      dataOutReadyLine <= shift_q[23];
      shift_q          <= {shift_q[22:0], 1'b1};
      if (bitCnt_q == `SDR_WORD_BITS - 5'd1)
      begin
        bitCnt_q <= 5'd0;
        loaded_q <= 1'b0;
      end
      else
        bitCnt_q <= bitCnt_q + 5'd1;
    end
    // Limitation: a result that completes during a read is dropped, not queued.
    // While the serial clock is high the last bit may still be sampled, so a result that completes then is not loaded.
    else if (decEn && bitCnt_q == 5'd0 && !sclkSync_q)
    begin
      shift_q          <= result;
      loaded_q         <= 1'b1;
      dataOutReadyLine <= 1'b0;
    end
    else if (!loaded_q && sclkSync_q == 1'b0 && bitCnt_q == 5'd0 && sclkLast_q)
      dataOutReadyLine <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Held-high detection and settling count
  // ----------------------------------------------------------------
  // Counts clocks with the serial clock high, saturating at the sleep limit.
  reg [19:0] highCnt_q;

  // An idle-high clock beyond a word's span means resync, longer means sleep.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      highCnt_q   <= 20'd0;
      modResync   <= 1'b0;
      powerDown   <= 1'b0;
      settleCnt_q <= 3'd0;
      settled     <= 1'b0;
    end
    else
    begin
      if (!sclkSync_q)
        highCnt_q <= 20'd0;
      else if (highCnt_q != PDOWN_CYCLES[19:0])
        highCnt_q <= highCnt_q + 20'd1;
      modResync <= sclkSync_q && highCnt_q == RESYNC_CYCLES[19:0] - 20'd1;
      powerDown <= sclkSync_q && highCnt_q >= PDOWN_CYCLES[19:0] - 20'd1;
      if (modResync || powerDown)
      begin
        settleCnt_q <= 3'd0;
        settled     <= 1'b0;
      end
      else if (decEn && settleCnt_q != `SDR_SETTLE_CONV)
      begin
        settleCnt_q <= settleCnt_q + 3'd1;
        settled     <= (settleCnt_q == `SDR_SETTLE_CONV - 3'd1);
      end
    end
  end

endmodule

// ---- sdr_readout_monitor.sv ----
// Port checker for the serial readout block.
`timescale 1ns/10ps
module sdr_readout_monitor
#(
  parameter RESYNC_CYCLES = 1000,
  parameter PDOWN_CYCLES  = 200000
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic modBit,
  input wire logic serialClk,
  input wire logic dataOutReadyLine,
  input wire logic modResync,
  input wire logic powerDown,
  input wire logic settled
);
  // ------------------------------------------------------------
  // Serial clock history and port relations
  // ------------------------------------------------------------
  logic [7:0] hist_q;
  // History needs no reset: it is full of real samples long before reset ends.
  always_ff @(posedge clock)
    hist_q <= {hist_q[6:0], serialClk};
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_PD: assert property ($rose(powerDown) |-> &hist_q)
    else $error("power-down without held clock");
  AST_RS: assert property ($rose(modResync) |-> &hist_q)
    else $error("resync without held clock");
  AST_PULSE: assert property (modResync |=> !modResync)
    else $error("resync pulse too long");
  AST_PD_SET: assert property (powerDown |=> !settled)
    else $error("settled in power-down");
  AST_RS_SET: assert property (modResync |=> !settled)
    else $error("settled kept after resync");
  AST_READY: assert property (!dataOutReadyLine && !serialClk && !(|hist_q) |=> !dataOutReadyLine)
    else $error("ready flag dropped unread");
  AST_HOLD: assert property ((!serialClk)[*8] |-> $stable(dataOutReadyLine) || $fell(dataOutReadyLine))
    else $error("data moved without clock");
  AST_ROSE: assert property ($rose(dataOutReadyLine) |-> |hist_q)
    else $error("line rose without clock");
  cover property ($fell(dataOutReadyLine));
  cover property ($rose(settled));
  cover property ($rose(powerDown));
endmodule
bind sdr_readout sdr_readout_monitor #(.RESYNC_CYCLES(RESYNC_CYCLES), .PDOWN_CYCLES(PDOWN_CYCLES))
  u_sdr_readout_monitor (.clock(clock), .reset(reset), .modBit(modBit), .serialClk(serialClk),
  .dataOutReadyLine(dataOutReadyLine), .modResync(modResync), .powerDown(powerDown),
  .settled(settled));

// ---- sdr_readout_test.sv ----
// Self-checking bench for the serial readout block.
`timescale 1ns/10ps
`define CK(n, e, a) begin totalChecks++; if ((a) !== (e)) begin nFail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module sdr_readout_test;
  logic clock, reset, modBit, serialClk, dataOutReadyLine, modResync, powerDown, settled;
  int nFail, totalChecks, n;
  longint t0;
  sdr_readout #(.RESYNC_CYCLES(50), .PDOWN_CYCLES(200)) u_sdr_readout (.clock(clock),
    .reset(reset), .modBit(modBit), .serialClk(serialClk), .dataOutReadyLine(dataOutReadyLine),
    .modResync(modResync), .powerDown(powerDown), .settled(settled));
  sdr_host_model u_sdr_host_model (.dataOutReadyLine(dataOutReadyLine), .serialClk(serialClk));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task stopTest();
    if (nFail == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for the ready flag; running out ends the run.
  task waitReady();
    n = 0;
    while (dataOutReadyLine !== 1'b0)
    begin
      @(negedge clock);
      n++;
      if (n > 3000)
      begin
        nFail++;
        stopTest();
      end
    end
  endtask
  // Six words with a constant input stream; the filter is settled by the last.
  task readWords(input logic [23:0] exp);
    repeat (6)
    begin
      waitReady();
      u_sdr_host_model.readWord();
    end
    `CK("word", exp, u_sdr_host_model.word)
    `CK("settled", 1'b1, settled)
    repeat (6) @(negedge clock);
    `CK("idle", 1'b1, dataOutReadyLine)
  endtask
  // Two ready flags should stand 6 x 64 clocks apart.
  task readRate();
    waitReady();
    t0 = $time;
    u_sdr_host_model.readWord();
    waitReady();
    `CK("period", 384, ($time - t0) / 20)
  endtask
  // Hold the clock high past both thresholds, then release it.
  task holdLong();
    n = 0;
    fork
      u_sdr_host_model.holdHigh(6000);
      begin
        repeat (290) @(negedge clock) n += modResync;
        `CK("pdown", 1'b1, powerDown)
      end
    join
    `CK("resyncs", 1, n)
    repeat (8) @(negedge clock);
    `CK("wake", 1'b0, powerDown)
    `CK("unsettled", 1'b0, settled)
  endtask
  initial
  begin
    reset = 1'b1;
    modBit = 1'b1;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    readWords(24'hffffff);
    readRate();
    modBit = 1'b0;
    readWords(24'h000000);
    holdLong();
    stopTest();
  end
endmodule

// ---- sdr_regs.vh ----
// Constants for the sigma-delta converter serial readout block.
`ifndef SDR_REGS_VH
`define SDR_REGS_VH
`define SDR_MOD_DIV        3'd6
`define SDR_OSR            6'd63
`define SDR_WORD_BITS      5'd24
`define SDR_ACC_BITS       36
`define SDR_SETTLE_CONV    3'd5
`define SDR_RESYNC_CYCLES  20'd1000
`define SDR_PDOWN_CYCLES   20'd200000
`endif
